// ===== flash_sec_defines.svh
// Purpose : constants of the flash security and mass-wipe sequencer
// Assumes : 100 MHz system clock
// Notes   : field codes of the security byte are held here once
//
// Functional notes
// - External wipe erases all flash ignoring guards, then unlocks live and stored.
// - Mass-wipe request flag reads set during external wipe, clears at end.
// - Key check is code 0x45; bytes four to eleven hold the key.
// - Key bytes compare to stored offsets in reversed order per group of four.
// - Key check without backdoor permit sets access error, no compare.
// - Matching key sets lock-state field to unsecure.
// - After a mismatch every later key check aborts with access error until reset.
// - All-zero or all-one key fails with access error.
// - Command-done flag sets again when key check ends, any outcome.
// - Code 0x49 launch erases all flash then verifies it.
// - Wipe-unlock pass unlocks live and stored; failure sets verify-fail; done sets.
// - Wipe-unlock in a forbidden mode or state reports access error; the code admits 0x49 in every mode and security state.
// - Special mode while secured allows only the wipe and blank-check commands.
// - Reset loads the live security register from the stored byte.
// - Programming the stored byte changes live state only after next reset.
// - Key success alters only the live register, nothing stored.
// - Reset sequence loads registers, holds done low, sets it at the end.
// - Processor access stalls during the reset sequence.
// - Reset aborts any running command; it never resumes.
// - Code 0x44 aborts with guard violation if any region is protected.
`ifndef FLASH_SEC_DEFINES_SVH
`define FLASH_SEC_DEFINES_SVH

// ----------------------------------------------------------------------
// command codes and byte positions
// ----------------------------------------------------------------------
`define CMD_BLANK_CHECK_ALL 8'h40
`define CMD_WIPE_ALL        8'h44
`define CMD_KEY_CHECK       8'h45
`define CMD_WIPE_UNLOCK     8'h49
`define CMD_BYTE_COUNT      12
`define KEY_FIRST_BYTE      4
`define KEY_BYTE_COUNT      8

// ----------------------------------------------------------------------
// security byte layout and codes
// ----------------------------------------------------------------------
`define SEC_LOCK_LSB        0
`define SEC_FACTORY_LSB     2
`define SEC_WIPE_PERMIT_LSB 4
`define SEC_BACKDOOR_LSB    6
`define SEC_UNSECURE        2'h2
`define SEC_BACKDOOR_ON     2'h2
`define SEC_RESET_VALUE     8'hFF
`define GUARD_RESET_VALUE   32'hFFFFFFFF
`define OPTION_RESET_VALUE  8'hFF

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define RST_SEQ_NS          80
`define RST_SEQ_CYCLES      ((`RST_SEQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== flash_sec_pkg.sv
// Purpose : types of the flash security and mass-wipe sequencer
// Assumes : constants come from flash_sec_defines.svh
// Notes   : the whole sequencer state is one packed struct
package flash_sec_pkg;

    // ------------------------------------------------------------------
    // sequencer states and array operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET,
        ST_IDLE,
        ST_KEY,
        ST_ERASE,
        ST_PROG,
        ST_FINISH
    } seq_state_t;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ERASE_ALL,
        OP_PROG_SEC
    } array_op_t;

    // ------------------------------------------------------------------
    // status flags and whole state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic access_error;
        logic guard_violation;
        logic verify_fail;
        logic command_done;
        logic mass_wipe_request;
    } status_flags_t;

    typedef struct packed {
        seq_state_t    state;
        logic [3:0]    rst_cnt;
        logic          hold;
        status_flags_t flags;
        logic [7:0]    prot_state;
        logic [31:0]   guard;
        logic [7:0]    option;
        logic          key_locked;
        logic          program_sec;
        array_op_t     op;
        logic [1:0]    wipe_sync;
        logic          wipe_prev;
    } seq_regs_t;

endpackage

// ===== cmd_byte_store.sv
// Purpose : holds the twelve command parameter bytes
// Assumes : writer is on the system clock
// Notes   : reads come straight from the storage flops
`timescale 1ns/1ns
`include "flash_sec_defines.svh"
module cmd_byte_store (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // write side
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_idx_i,
    input  wire logic [7:0]  wr_data_i,
    // read side
    output logic      [95:0] bytes_o
);
    logic [95:0] store;
    logic [95:0] next_store;

    // byte lane update; indices past the last byte are dropped
    always_comb begin
        next_store = store;
        if (wr_en_i && (wr_idx_i < 4'(`CMD_BYTE_COUNT))) begin
            next_store[8*wr_idx_i +: 8] = wr_data_i;
        end
    end

    // cleared at reset so byte zero never holds a wipe code by accident
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            store <= 96'h0;
        end else if (clk_en_i) begin
            store <= next_store;
        end
    end

    assign bytes_o = store;
endmodule

// ===== key_checker.sv
// Purpose : compares a candidate backdoor key with the stored key
// Assumes : stored key byte at offset n sits at bits 8n+7..8n
// Notes   : purely combinational; the inputs are stable while it is read
`timescale 1ns/1ns
`include "flash_sec_defines.svh"
module key_checker (
    // candidate key, key byte zero in the low byte
    input  wire logic [63:0] cand_i,
    // stored key by field offset
    input  wire logic [63:0] stored_i,
    // results
    output logic             match_o,
    output logic             all_zero_o,
    output logic             all_ones_o
);
    logic [7:0] byte_eq;

    // each group of four bytes is compared in reversed order
    genvar k;
    generate
        for (k = 0; k < `KEY_BYTE_COUNT; k++) begin : g_byte
            localparam int OFS = (k < 4) ? (3 - k) : (11 - k);
            assign byte_eq[k] = (cand_i[8*k +: 8] == stored_i[8*OFS +: 8]);
        end
    endgenerate

    assign match_o    = &byte_eq;
    assign all_zero_o = (cand_i == 64'h0);
    assign all_ones_o = (cand_i == 64'hFFFFFFFFFFFFFFFF);
endmodule

// ===== flash_security_unlock_erase.sv
// Purpose : security, backdoor key check and mass-wipe sequencer of the flash controller
// Assumes : array, mode and configuration inputs are on clk_i; external wipe pin is not
// Notes   : launch_i is the write that clears the command-done flag
`timescale 1ns/1ns
`include "flash_sec_defines.svh"
module flash_security_unlock_erase
    import flash_sec_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // command parameter bytes and launch
    input  wire logic        cmd_wr_i,
    input  wire logic [3:0]  cmd_wr_idx_i,
    input  wire logic [7:0]  cmd_wr_data_i,
    input  wire logic        launch_i,
    // write-one-to-clear strobes of the status flags
    input  wire logic        clr_access_error_i,
    input  wire logic        clr_guard_violation_i,
    input  wire logic        clr_verify_fail_i,
    // mode and external wipe trigger
    input  wire logic        special_mode_i,
    input  wire logic        ext_wipe_i,
    // stored configuration field
    input  wire logic [7:0]  cfg_security_byte_i,
    input  wire logic [63:0] cfg_key_i,
    input  wire logic [31:0] cfg_guard_i,
    input  wire logic [7:0]  cfg_option_i,
    input  wire logic        any_region_guarded_i,
    // flash array engine
    input  wire logic        array_done_i,
    input  wire logic        array_pass_i,
    output array_op_t        array_op_o,
    // status
    output logic             command_done_flag_o,
    output logic             access_error_flag_o,
    output logic             guard_violation_flag_o,
    output logic             verify_fail_flag_o,
    output logic             mass_wipe_request_flag_o,
    output logic [7:0]       protection_state_reg_o,
    output logic [31:0]      write_guard_regs_o,
    output logic [7:0]       boot_option_reg_o,
    output logic             cpu_hold_o
);
    // ------------------------------------------------------------------
    // constants and state
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_LAST = 4'(`RST_SEQ_CYCLES - 1);

    localparam seq_regs_t RESET_REGS = '{
        state:       ST_RESET,
        rst_cnt:     4'h0,
        hold:        1'b1,
        flags:       '0,
        prot_state:  `SEC_RESET_VALUE,
        guard:       `GUARD_RESET_VALUE,
        option:      `OPTION_RESET_VALUE,
        key_locked:  1'b0,
        program_sec: 1'b0,
        op:          OP_NONE,
        wipe_sync:   2'h0,
        wipe_prev:   1'b0
    };

    seq_regs_t   s;
    seq_regs_t   next_s;
    logic [95:0] cmd_bytes;
    logic [7:0]  cmd_zero;
    logic        key_match;
    logic        key_all_zero;
    logic        key_all_ones;
    logic        unsecure;
    logic        allowed;
    logic        launch_ok;
    logic        wipe_rise;

    // ------------------------------------------------------------------
    // command bytes and key compare
    // ------------------------------------------------------------------
    cmd_byte_store u_store (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .wr_en_i   (cmd_wr_i && s.flags.command_done),
        .wr_idx_i  (cmd_wr_idx_i),
        .wr_data_i (cmd_wr_data_i),
        .bytes_o   (cmd_bytes)
    );

    key_checker u_key (
        .cand_i     (cmd_bytes[8*`KEY_FIRST_BYTE +: 64]),
        .stored_i   (cfg_key_i),
        .match_o    (key_match),
        .all_zero_o (key_all_zero),
        .all_ones_o (key_all_ones)
    );

    // ------------------------------------------------------------------
    // command qualification
    // ------------------------------------------------------------------
    assign cmd_zero  = cmd_bytes[7:0];
    assign unsecure  = (s.prot_state[`SEC_LOCK_LSB +: 2] == `SEC_UNSECURE);
    // secured special mode admits only the wipe and blank-check codes
    assign allowed   = !special_mode_i || unsecure ||
                       (cmd_zero == `CMD_WIPE_ALL) ||
                       (cmd_zero == `CMD_WIPE_UNLOCK) ||
                       (cmd_zero == `CMD_BLANK_CHECK_ALL);
    // an external wipe edge in the same cycle takes priority over a launch
    assign launch_ok = launch_i && s.flags.command_done && (s.state == ST_IDLE) && !wipe_rise;
    // edge of the synchronised pin; only the second stage is looked at
    assign wipe_rise = s.wipe_sync[1] && !s.wipe_prev;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.wipe_sync = {s.wipe_sync[0], ext_wipe_i};
        next_s.wipe_prev = s.wipe_sync[1];
        // clears first, so a hardware set below in the same cycle wins
        if (clr_access_error_i) begin
            next_s.flags.access_error = 1'b0;
        end
        if (clr_guard_violation_i) begin
            next_s.flags.guard_violation = 1'b0;
        end
        if (clr_verify_fail_i) begin
            next_s.flags.verify_fail = 1'b0;
        end
        case (s.state)
            ST_RESET: begin
                next_s.hold               = 1'b1;
                next_s.flags.command_done = 1'b0;
                if (s.rst_cnt == RST_LAST) begin
                    next_s.prot_state         = cfg_security_byte_i;
                    next_s.guard              = cfg_guard_i;
                    next_s.option             = cfg_option_i;
                    next_s.hold               = 1'b0;
                    next_s.flags.command_done = 1'b1;
                    next_s.state              = ST_IDLE;
                end else begin
                    next_s.rst_cnt = s.rst_cnt + 4'h1;
                end
            end
            ST_IDLE: begin
                if (wipe_rise && s.flags.command_done) begin
                    // the requester keeps byte zero off the wipe-all code
                    next_s.flags.mass_wipe_request = 1'b1;
                    next_s.flags.command_done      = 1'b0;
                    next_s.program_sec             = 1'b1;
                    next_s.op                      = OP_ERASE_ALL;
                    next_s.state                   = ST_ERASE;
                end else if (launch_ok) begin
                    next_s.flags.command_done = 1'b0;
                    next_s.state              = ST_FINISH;
                    case (cmd_zero)
                        `CMD_KEY_CHECK: begin
                            if (!allowed || s.key_locked ||
                                (s.prot_state[`SEC_BACKDOOR_LSB +: 2] != `SEC_BACKDOOR_ON) ||
                                key_all_zero || key_all_ones) begin
                                next_s.flags.access_error = 1'b1;
                            end else begin
                                next_s.state = ST_KEY;
                            end
                        end
                        `CMD_WIPE_UNLOCK: begin
                            if (!allowed) begin
                                next_s.flags.access_error = 1'b1;
                            end else begin
                                next_s.program_sec = 1'b1;
                                next_s.op          = OP_ERASE_ALL;
                                next_s.state       = ST_ERASE;
                            end
                        end
                        `CMD_WIPE_ALL: begin
                            if (!allowed) begin
                                next_s.flags.access_error = 1'b1;
                            end else if (any_region_guarded_i) begin
                                next_s.flags.guard_violation = 1'b1;
                            end else begin
                                next_s.program_sec = 1'b0;
                                next_s.op          = OP_ERASE_ALL;
                                next_s.state       = ST_ERASE;
                            end
                        end
                        default: begin
                            // codes handled elsewhere in the controller
                            next_s.flags.access_error = 1'b1;
                        end
                    endcase
                end
            end
            ST_KEY: begin
                // only the live register moves; stored byte, keys and guards stay
                if (key_match) begin
                    next_s.prot_state[`SEC_LOCK_LSB +: 2] = `SEC_UNSECURE;
                end else begin
                    next_s.key_locked         = 1'b1;
                    next_s.flags.access_error = 1'b1;
                end
                next_s.state = ST_FINISH;
            end
            ST_ERASE: begin
                if (array_done_i) begin
                    next_s.op    = OP_NONE;
                    next_s.state = ST_FINISH;
                    if (!array_pass_i) begin
                        next_s.flags.verify_fail = 1'b1;
                    end else if (s.program_sec) begin
                        next_s.op    = OP_PROG_SEC;
                        next_s.state = ST_PROG;
                    end else begin
                        next_s.prot_state[`SEC_LOCK_LSB +: 2] = `SEC_UNSECURE;
                    end
                end
            end
            ST_PROG: begin
                if (array_done_i) begin
                    next_s.op    = OP_NONE;
                    next_s.state = ST_FINISH;
                    if (array_pass_i) begin
                        next_s.prot_state[`SEC_LOCK_LSB +: 2] = `SEC_UNSECURE;
                    end else begin
                        next_s.flags.verify_fail = 1'b1;
                    end
                end
            end
            ST_FINISH: begin
                next_s.flags.command_done      = 1'b1;
                next_s.flags.mass_wipe_request = 1'b0;
                next_s.program_sec             = 1'b0;
                next_s.state                   = ST_IDLE;
            end
            default: begin
                next_s = RESET_REGS;
            end
        endcase
    end

    // reset drops any running operation and restarts the load sequence
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= RESET_REGS;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state flops
    // ------------------------------------------------------------------
    assign array_op_o               = s.op;
    assign command_done_flag_o      = s.flags.command_done;
    assign access_error_flag_o      = s.flags.access_error;
    assign guard_violation_flag_o   = s.flags.guard_violation;
    assign verify_fail_flag_o       = s.flags.verify_fail;
    assign mass_wipe_request_flag_o = s.flags.mass_wipe_request;
    assign protection_state_reg_o   = s.prot_state;
    assign write_guard_regs_o       = s.guard;
    assign boot_option_reg_o        = s.option;
    assign cpu_hold_o               = s.hold;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_key_unlock: assert property (clk_en_i && s.state == ST_KEY && key_match |=>
        s.prot_state[`SEC_LOCK_LSB +: 2] == `SEC_UNSECURE && s.state == ST_FINISH)
        else $error("matching key did not unlock");
    a_key_lockout: assert property (clk_en_i && s.state == ST_KEY && !key_match |=>
        s.key_locked && s.flags.access_error)
        else $error("mismatch did not lock the key check");
    a_locked_abort: assert property (clk_en_i && launch_ok && s.key_locked &&
        cmd_zero == `CMD_KEY_CHECK |=> s.state == ST_FINISH && s.flags.access_error)
        else $error("locked key check was not aborted");
    a_trivial_key: assert property (clk_en_i && launch_ok && cmd_zero == `CMD_KEY_CHECK &&
        (key_all_zero || key_all_ones) |=> s.flags.access_error && s.state != ST_KEY)
        else $error("trivial key not refused");
    a_permit_gate: assert property (clk_en_i && launch_ok && cmd_zero == `CMD_KEY_CHECK &&
        s.prot_state[`SEC_BACKDOOR_LSB +: 2] != `SEC_BACKDOOR_ON |=> s.state == ST_FINISH)
        else $error("key compared without permit");
    a_done_after: assert property (clk_en_i && s.state == ST_FINISH |=>
        s.flags.command_done && s.state == ST_IDLE)
        else $error("done flag not set at the end");
    a_wipe_flag: assert property (s.state == ST_ERASE && s.program_sec &&
        s.flags.mass_wipe_request |-> !s.flags.command_done)
        else $error("wipe request flag with done set");
    a_reset_hold: assert property (s.state == ST_RESET |->
        !s.flags.command_done && s.hold)
        else $error("done or hold wrong in reset sequence");
    a_guard_abort: assert property (clk_en_i && launch_ok && cmd_zero == `CMD_WIPE_ALL &&
        allowed && any_region_guarded_i |=> s.flags.guard_violation && s.op == OP_NONE)
        else $error("guarded wipe-all not aborted");
    a_bytes_frozen: assert property (!s.flags.command_done |=> $stable(cmd_bytes))
        else $error("command bytes changed while busy");

    c_key_ok:    cover property (s.state == ST_KEY && key_match);
    c_key_bad:   cover property (s.state == ST_KEY && !key_match);
    c_ext_wipe:  cover property (s.state == ST_FINISH && s.flags.mass_wipe_request);
    c_unlock_ok: cover property (s.state == ST_PROG && array_done_i && array_pass_i);
endmodule

// ===== flash_security_unlock_erase_tb.sv
// Purpose : self-checking bench of the security and mass-wipe sequencer
// Assumes : stimulus at the falling edge, array engine answers pass or fail on request
// Notes   : assertions live in the design files, this bench only drives and compares
`timescale 1ns/1ns
`include "flash_sec_defines.svh"
module testbench
    import flash_sec_pkg::*;
;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, cmd_wr_i = 1'b0;
    logic [3:0]  cmd_wr_idx_i = 4'h0;
    logic [7:0]  cmd_wr_data_i = 8'h00, cfg_security_byte_i = 8'h3F, cfg_option_i = 8'h5A;
    logic        launch_i = 1'b0, clr_access_error_i = 1'b0, clr_guard_violation_i = 1'b0;
    logic        clr_verify_fail_i = 1'b0, special_mode_i = 1'b0, ext_wipe_i = 1'b0;
    logic [63:0] cfg_key_i = 64'h0123456789ABCDEF;
    logic [31:0] cfg_guard_i = 32'h12345678;
    logic        any_region_guarded_i = 1'b0, array_done_i = 1'b0, array_pass_i = 1'b1;
    array_op_t   array_op_o;
    logic        command_done_flag_o, access_error_flag_o, guard_violation_flag_o;
    logic        verify_fail_flag_o, mass_wipe_request_flag_o, cpu_hold_o, seen_prog;
    logic [7:0]  protection_state_reg_o, boot_option_reg_o;
    logic [31:0] write_guard_regs_o;
    logic [63:0] good;
    int          error_cnt = 0, num_checks = 0, cycles = 0;

    flash_security_unlock_erase i_dut (.clk_i, .sys_rst_i, .clk_en_i, .cmd_wr_i, .cmd_wr_idx_i,
        .cmd_wr_data_i, .launch_i, .clr_access_error_i, .clr_guard_violation_i,
        .clr_verify_fail_i, .special_mode_i, .ext_wipe_i, .cfg_security_byte_i, .cfg_key_i,
        .cfg_guard_i, .cfg_option_i, .any_region_guarded_i, .array_done_i, .array_pass_i,
        .array_op_o, .command_done_flag_o, .access_error_flag_o, .guard_violation_flag_o,
        .verify_fail_flag_o, .mass_wipe_request_flag_o, .protection_state_reg_o,
        .write_guard_regs_o, .boot_option_reg_o, .cpu_hold_o);

    // ------------------------------------------------------------------
    // clock, array engine stand-in and hang guard
    // ------------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    // answer every other cycle so a held operation still finishes quickly
    always @(negedge clk_i) array_done_i <= (array_op_o != OP_NONE) && !array_done_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        // a launch forgets the program step of any earlier command
        if (launch_i) seen_prog <= 1'b0;
        else if (array_op_o === OP_PROG_SEC) seen_prog <= 1'b1;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [3:0] idx, input logic [7:0] d);
        @(negedge clk_i) {cmd_wr_i, cmd_wr_idx_i, cmd_wr_data_i} = {1'b1, idx, d};
        @(negedge clk_i) cmd_wr_i = 1'b0;
    endtask
    // launch a command and optionally wait, bounded, for done to return
    task automatic run(input logic [7:0] code, input bit wt);
        put(4'h0, code);
        @(negedge clk_i) launch_i = 1'b1;
        @(negedge clk_i) launch_i = 1'b0;
        for (int i = 0; wt && i < 60 && command_done_flag_o !== 1'b1; i++) @(negedge clk_i);
    endtask
    task automatic key(input logic [63:0] k);
        for (int i = 0; i < 8; i++) put(4'(4 + i), k[8*i +: 8]);
        run(`CMD_KEY_CHECK, 1);
    endtask
    task automatic clr();
        @(negedge clk_i) {clr_access_error_i, clr_guard_violation_i, clr_verify_fail_i} = 3'h7;
        @(negedge clk_i) {clr_access_error_i, clr_guard_violation_i, clr_verify_fail_i} = 3'h0;
    endtask
    // reset with a given stored security byte; done must stay low for seven edges after release and set on the eighth
    task automatic do_reset(input logic [7:0] sec);
        @(negedge clk_i) {sys_rst_i, cfg_security_byte_i} = {1'b1, sec};
        repeat (8) @(negedge clk_i);
        chk({cpu_hold_o, command_done_flag_o, array_op_o}, {2'h2, OP_NONE});
        sys_rst_i = 1'b0;
        repeat (7) @(negedge clk_i);
        chk({cpu_hold_o, command_done_flag_o}, 2'h2);
        @(negedge clk_i);
        chk({cpu_hold_o, command_done_flag_o, protection_state_reg_o}, {2'h1, sec});
        chk({write_guard_regs_o, boot_option_reg_o}, {cfg_guard_i, cfg_option_i});
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        // key byte k matches offset 3-k in the first group, 11-k in the second
        for (int k = 0; k < 8; k++) good[8*k +: 8] = cfg_key_i[8*(k < 4 ? 3-k : 11-k) +: 8];
        do_reset(8'h3F);
        key(good);
        chk({access_error_flag_o, command_done_flag_o, protection_state_reg_o}, 10'h33F);
        do_reset(8'hBF);
        key(good);
        chk({access_error_flag_o, protection_state_reg_o[1:0]}, 3'h2);
        do_reset(8'hBF);
        key(64'h0);
        chk(access_error_flag_o, 1'b1);
        clr();
        key(cfg_key_i);
        chk({access_error_flag_o, protection_state_reg_o}, 9'h1BF);
        clr();
        key(good);
        chk({access_error_flag_o, protection_state_reg_o}, 9'h1BF);
        // a clear strobe while the enable is low must leave the flag alone
        clk_en_i = 1'b0;
        clr();
        chk(access_error_flag_o, 1'b1);
        clk_en_i = 1'b1;
        clr();
        any_region_guarded_i = 1'b1;
        run(`CMD_WIPE_ALL, 1);
        chk({guard_violation_flag_o, protection_state_reg_o}, 9'h1BF);
        {any_region_guarded_i, cfg_security_byte_i} = {1'b0, 8'hBE};
        clr();
        chk(protection_state_reg_o, 8'hBF);
        run(`CMD_WIPE_UNLOCK, 1);
        chk({seen_prog, verify_fail_flag_o, protection_state_reg_o[1:0]}, 4'hA);
        do_reset(8'hBF);
        array_pass_i = 1'b0;
        run(`CMD_WIPE_UNLOCK, 1);
        chk({verify_fail_flag_o, command_done_flag_o, protection_state_reg_o}, 10'h3BF);
        {array_pass_i, special_mode_i} = 2'h3;
        clr();
        key(good);
        chk(access_error_flag_o, 1'b1);
        clr();
        run(`CMD_WIPE_ALL, 1);
        chk({access_error_flag_o, protection_state_reg_o[1:0]}, 3'h2);
        run(`CMD_WIPE_UNLOCK, 0);
        do_reset(8'hBF);
        special_mode_i = 1'b0;
        // flags and byte zero were cleared by the reset just above
        ext_wipe_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({mass_wipe_request_flag_o, command_done_flag_o}, 2'h2);
        ext_wipe_i = 1'b0;
        for (int i = 0; i < 60 && command_done_flag_o !== 1'b1; i++) @(negedge clk_i);
        chk({mass_wipe_request_flag_o, protection_state_reg_o[1:0]}, 3'h2);
        final_report();
    end
endmodule
